//--- pkg/sram_ctl_pkg.sv
// Constants and timing for the asynchronous byte-wide memory controller.
// Operation
// - Write happens while select and write strobe are both low.
// - Read happens with select and output drive low, write strobe high.
// - Controller waits at least 100 us after power before first access.
// - Address stable from write start until write end.
// - Address presented at least 6 or 7 ns before write ends.
// - Write data set up 4 or 5 ns before write end, held 0 ns.
// - Controller must not drive data while device drives it.
package sram_ctl_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 25000;
  // Slower grade figures are used so either grade of part works.
  localparam int POWER_UP_US = 100;
  localparam int ACCESS_NS = 10;
  localparam int OE_ACCESS_NS = 5;
  localparam int ADDR_SETUP_NS = 7;
  localparam int DATA_SETUP_NS = 5;
  localparam int PULSE_NS = 7;
  localparam int FLOAT_NS = 5;
  localparam int POWER_UP_CYC = (POWER_UP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_CYC = (PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLOAT_CYC = (FLOAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 12;
endpackage : sram_ctl_pkg

//--- pkg/sram_pins_if.sv
// Pin bundle between the sequencer and the pin driver.
`timescale 1ns/1ps
interface sram_pins_if;
  import sram_ctl_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic sel;
  logic oe;
  logic we;
  logic drive;
  modport seq (output addr, output wdata, output sel, output oe, output we, output drive);
  modport pins (input addr, input wdata, input sel, input oe, input we, input drive);
endinterface : sram_pins_if

//--- logic/sram_pin_drive.sv
// Registered pin stage turning sequencer requests into active-low strobes.
`timescale 1ns/1ps
module sram_pin_drive
  import sram_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  sram_pins_if.pins p,
  output logic [ADDR_W-1:0] addr_lines,
  output logic chip_select_n,
  output logic output_drive_n,
  output logic write_strobe_n,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe
);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      chip_select_n <= 1'b1;
      output_drive_n <= 1'b1;
      write_strobe_n <= 1'b1;
      addr_lines <= '0;
    end
    else
    begin
      chip_select_n <= ~p.sel;
      output_drive_n <= ~p.oe;
      write_strobe_n <= ~p.we;
      addr_lines <= p.addr;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      data_out <= '0;
      data_oe <= 1'b0;
    end
    else
    begin
      data_out <= p.wdata;
      data_oe <= p.drive;
    end
  end
endmodule : sram_pin_drive

//--- logic/sram_ctl.sv
// Controller sequencing reads and writes to an asynchronous byte-wide memory.
`timescale 1ns/1ps
module sram_ctl
  import sram_ctl_pkg::*;
#(
  parameter int POWER_WAIT_CYC = POWER_UP_CYC
)
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RD_VALID,
  output logic [DATA_W-1:0] RD_DATA,
  output logic [ADDR_W-1:0] ADDR_LINES,
  output logic CHIP_SELECT_N,
  output logic OUTPUT_DRIVE_N,
  output logic WRITE_STROBE_N,
  output logic [DATA_W-1:0] DATA_LINES_O,
  output logic DATA_LINES_OE,
  input wire logic [DATA_W-1:0] DATA_LINES_I
);
  typedef enum logic [2:0] {S_POWER, S_IDLE, S_WSETUP, S_WPULSE, S_WEND, S_READ, S_RFLOAT} state_e;

  state_e state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] pwr_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic is_write_ff;
  logic pwr_done;

  sram_pins_if pins ();

  // ==========================================================================
  // State decode
  // ==========================================================================
  // Write states share one decode so select and data drive can never disagree in a write state.
  function automatic logic in_write(input state_e s);
    return s inside {S_WSETUP, S_WPULSE, S_WEND};
  endfunction : in_write

  // ==========================================================================
  // Power-up wait
  // ==========================================================================
  assign pwr_done = (pwr_ff >= CNT_W'(POWER_WAIT_CYC));

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      pwr_ff <= '0;
    else if (!pwr_done)
      pwr_ff <= pwr_ff + 1'b1;
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  assign REQ_READY = (state_ff == S_IDLE);

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      state_ff <= S_POWER;
      cnt_ff <= '0;
      addr_ff <= '0;
      wdata_ff <= '0;
      is_write_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        S_POWER:
          if (pwr_done)
            state_ff <= S_IDLE;
        S_IDLE:
          if (REQ_VALID)
          begin
            addr_ff <= REQ_ADDR;
            wdata_ff <= REQ_WDATA;
            is_write_ff <= REQ_WRITE;
            cnt_ff <= '0;
            state_ff <= REQ_WRITE ? S_WSETUP : S_READ;
          end
        S_WSETUP:
          // Address and data lead the strobe by one cycle, which covers setup.
          state_ff <= S_WPULSE;
        S_WPULSE:
          if (cnt_ff == CNT_W'(PULSE_CYC - 1))
            state_ff <= S_WEND;
          else
            cnt_ff <= cnt_ff + 1'b1;
        S_WEND:
          state_ff <= S_IDLE;
        S_READ:
          // The extra count cycle covers the pin register, so the pins get only ACCESS_CYC cycles before sampling.
          if (cnt_ff == CNT_W'(ACCESS_CYC))
          begin
            cnt_ff <= '0;
            state_ff <= S_RFLOAT;
          end
          else
            cnt_ff <= cnt_ff + 1'b1;
        S_RFLOAT:
          // Keep our drivers off until the device has floated the bus.
          if (cnt_ff == CNT_W'(FLOAT_CYC))
            state_ff <= S_IDLE;
          else
            cnt_ff <= cnt_ff + 1'b1;
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Pin requests
  // ==========================================================================
  assign pins.addr = addr_ff;
  assign pins.wdata = wdata_ff;
  assign pins.sel = in_write(state_ff) || (state_ff == S_READ);
  assign pins.we = (state_ff == S_WPULSE);
  assign pins.oe = (state_ff == S_READ);
  assign pins.drive = in_write(state_ff);

  sram_pin_drive u_drive (
    .clk(REF_CLK),
    .rst(RESET),
    .p(pins.pins),
    .addr_lines(ADDR_LINES),
    .chip_select_n(CHIP_SELECT_N),
    .output_drive_n(OUTPUT_DRIVE_N),
    .write_strobe_n(WRITE_STROBE_N),
    .data_out(DATA_LINES_O),
    .data_oe(DATA_LINES_OE)
  );

  // ==========================================================================
  // Read capture
  // ==========================================================================
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      RD_VALID <= 1'b0;
      RD_DATA <= '0;
    end
    else
    begin
      RD_VALID <= 1'b0;
      if (state_ff == S_READ && cnt_ff == CNT_W'(ACCESS_CYC))
      begin
        RD_DATA <= DATA_LINES_I;
        RD_VALID <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_no_contention: assert property (@(posedge REF_CLK) disable iff (RESET)
    DATA_LINES_OE |-> OUTPUT_DRIVE_N)
    else $error("controller drives data while outputs enabled");
  a_strobe_needs_select: assert property (@(posedge REF_CLK) disable iff (RESET)
    !WRITE_STROBE_N |-> !CHIP_SELECT_N && DATA_LINES_OE)
    else $error("write strobe without select or data");
  a_addr_held_write: assert property (@(posedge REF_CLK) disable iff (RESET)
    !WRITE_STROBE_N |-> $stable(ADDR_LINES) && $stable(DATA_LINES_O))
    else $error("address or data moved during write");
  // One clock of strobe is far beyond the minimum pulse, so only the lead and the end are checked.
  a_addr_lead_write: assert property (@(posedge REF_CLK) disable iff (RESET)
    $fell(WRITE_STROBE_N) |-> !$past(CHIP_SELECT_N) && $stable(ADDR_LINES))
    else $error("address or select not set up before write strobe");
  a_write_pulse_end: assert property (@(posedge REF_CLK) disable iff (RESET)
    $fell(WRITE_STROBE_N) |-> ##[1:2] WRITE_STROBE_N)
    else $error("write strobe did not end");
  a_data_hold_end: assert property (@(posedge REF_CLK) disable iff (RESET)
    $rose(WRITE_STROBE_N) |-> DATA_LINES_OE && !CHIP_SELECT_N)
    else $error("data or select dropped with strobe");
  a_read_strobes: assert property (@(posedge REF_CLK) disable iff (RESET)
    !OUTPUT_DRIVE_N |-> !CHIP_SELECT_N && WRITE_STROBE_N)
    else $error("output enable outside read");
  a_read_result: assert property (@(posedge REF_CLK) disable iff (RESET)
    $fell(OUTPUT_DRIVE_N) |-> ##[1:2] RD_VALID)
    else $error("read result late");
  a_power_wait: assert property (@(posedge REF_CLK) disable iff (RESET)
    !pwr_done |-> CHIP_SELECT_N)
    else $error("access before power-up wait");
  a_float_gap: assert property (@(posedge REF_CLK) disable iff (RESET)
    $rose(OUTPUT_DRIVE_N) |-> !DATA_LINES_OE [*2])
    else $error("drove bus too soon after read");

  // ==========================================================================
  // Bus turn, result and power-up checks
  // ==========================================================================
  // Our data drivers may only be on inside a selected write window.
  a_drive_selected: assert property (@(posedge REF_CLK) disable iff (RESET)
    DATA_LINES_OE |-> !CHIP_SELECT_N && is_write_ff)
    else $error("data driven outside a write");
  a_data_setup: assert property (@(posedge REF_CLK) disable iff (RESET)
    !WRITE_STROBE_N |-> $past(DATA_LINES_OE))
    else $error("write data not set up before strobe");
  a_write_oe_off: assert property (@(posedge REF_CLK) disable iff (RESET)
    !WRITE_STROBE_N |-> OUTPUT_DRIVE_N)
    else $error("outputs enabled during write");
  // The captured byte is only trusted if the memory was driving when it was taken.
  a_read_sample: assert property (@(posedge REF_CLK) disable iff (RESET)
    RD_VALID |-> !$past(OUTPUT_DRIVE_N) && !$past(CHIP_SELECT_N))
    else $error("read data taken without outputs enabled");
  a_rd_valid_pulse: assert property (@(posedge REF_CLK) disable iff (RESET)
    RD_VALID |=> !RD_VALID)
    else $error("read valid longer than one cycle");
  a_ready_after_power: assert property (@(posedge REF_CLK) disable iff (RESET)
    REQ_READY |-> pwr_done)
    else $error("ready before power-up wait");
endmodule : sram_ctl

//--- testbench/byte_mem_model.sv
// Behavioural byte-wide asynchronous memory facing the controller.
`timescale 1ns/1ps
module byte_mem_model
  import sram_ctl_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr_lines,
  input wire logic chip_select_n,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_en
);
  // ==========================================================
  // Storage and pins
  logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];
  logic wr_on = 1'b0;
  logic standby;
  assign standby = chip_select_n;
  // A late 8 ns answer keeps the controller honest about its sampling margin.
  assign #8 data_en = !standby && !output_drive_n && write_strobe_n;
  assign #8 data_out = mem[addr_lines];
  // The byte is taken when the write ends, whichever strobe ends it.
  always @(chip_select_n or write_strobe_n)
  begin
    if (wr_on && (chip_select_n || write_strobe_n))
      mem[addr_lines] = data_in;
    wr_on = !chip_select_n && !write_strobe_n;
  end
endmodule : byte_mem_model

//--- testbench/sram_ctl_tb.sv
// Self-checking bench for the asynchronous memory controller.
`timescale 1ns/1ps
module sram_ctl_tb;
  import sram_ctl_pkg::*;
  localparam int PW = 4;
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  logic REQ_VALID = 1'b0;
  logic REQ_WRITE = 1'b0;
  logic [ADDR_W-1:0] REQ_ADDR = '0;
  logic [DATA_W-1:0] REQ_WDATA = '0;
  logic REQ_READY, RD_VALID, CHIP_SELECT_N, OUTPUT_DRIVE_N, WRITE_STROBE_N, DATA_LINES_OE, den, prev_we_n;
  logic [DATA_W-1:0] RD_DATA, DATA_LINES_O, bus, dq;
  logic [DATA_W-1:0] hold_v = 8'h00;
  logic [ADDR_W-1:0] ADDR_LINES, prev_addr;
  int errors = 0;
  int num_checks = 0;
  sram_ctl #(.POWER_WAIT_CYC(PW)) sram_ctl_inst (.REF_CLK(REF_CLK), .RESET(RESET), .REQ_VALID(REQ_VALID),
    .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY),
    .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .ADDR_LINES(ADDR_LINES), .CHIP_SELECT_N(CHIP_SELECT_N),
    .OUTPUT_DRIVE_N(OUTPUT_DRIVE_N), .WRITE_STROBE_N(WRITE_STROBE_N), .DATA_LINES_O(DATA_LINES_O),
    .DATA_LINES_OE(DATA_LINES_OE), .DATA_LINES_I(bus));
  byte_mem_model byte_mem_model_inst (.addr_lines(ADDR_LINES), .chip_select_n(CHIP_SELECT_N),
    .output_drive_n(OUTPUT_DRIVE_N), .write_strobe_n(WRITE_STROBE_N), .data_in(bus), .data_out(dq), .data_en(den));
  // ==========================================================
  // Bus level; a released bus toggles so stale data never looks valid.
  assign bus = DATA_LINES_OE ? DATA_LINES_O : (den ? dq : ~hold_v);
  always @(posedge REF_CLK) hold_v <= bus;
  initial forever #12.5 REF_CLK = ~REF_CLK;
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : chk
  // ==========================================================
  // Pin monitor
  always @(posedge REF_CLK)
  begin
    if (!RESET && DATA_LINES_OE) chk(den === 1'b0 && OUTPUT_DRIVE_N === 1'b1, "bus fight");
    if (!RESET && !WRITE_STROBE_N) chk(CHIP_SELECT_N === 1'b0 && DATA_LINES_OE === 1'b1, "write pins");
    if (!RESET && !WRITE_STROBE_N) chk(ADDR_LINES === prev_addr, "address moved");
    if (!RESET && WRITE_STROBE_N && !prev_we_n) chk(ADDR_LINES === prev_addr && DATA_LINES_OE, "hold");
    if (!RESET && !OUTPUT_DRIVE_N) chk(WRITE_STROBE_N === 1'b1 && CHIP_SELECT_N === 1'b0, "read pins");
    prev_addr <= ADDR_LINES;
    prev_we_n <= WRITE_STROBE_N;
  end
  // ==========================================================
  // Request drivers
  task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge REF_CLK);
    REQ_VALID <= 1'b1;
    REQ_WRITE <= w;
    REQ_ADDR <= a;
    REQ_WDATA <= d;
    do
    begin
      @(posedge REF_CLK);
      n++;
    end
    while (REQ_READY !== 1'b1 && n < 400);
    chk(n < 400, "request not taken");
    REQ_VALID <= 1'b0;
  endtask : req
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    req(1'b0, a, 8'h00);
    while (RD_VALID !== 1'b1 && n < 20)
    begin
      @(posedge REF_CLK);
      n++;
    end
    chk(n < 20 && RD_DATA === exp, "read data");
    @(posedge REF_CLK);
    chk(RD_VALID === 1'b0, "valid longer than one cycle");
  endtask : rd
  // ==========================================================
  // Scenarios
  task automatic t_power;
    int n;
    n = 0;
    @(posedge REF_CLK);
    RESET <= 1'b0;
    while (REQ_READY !== 1'b1 && n < 100)
    begin
      @(posedge REF_CLK);
      n++;
    end
    chk(n >= PW && n < 100, "ready before power-up wait or never");
  endtask : t_power
  task automatic t_rw;
    logic [ADDR_W-1:0] a [4] = '{19'h00000, 19'h7ffff, 19'h2a5a5, 19'h00001};
    logic [DATA_W-1:0] d [4] = '{8'h5a, 8'ha5, 8'hff, 8'h00};
    foreach (a[i]) req(1'b1, a[i], d[i]);
    foreach (a[i]) rd(a[i], d[i]);
    req(1'b1, 19'h00000, 8'h3c);
    rd(19'h00000, 8'h3c);
  endtask : t_rw
  task automatic t_reset_mid;
    req(1'b1, 19'h12345, 8'h77);
    repeat (3) @(posedge REF_CLK);
    RESET <= 1'b1;
    #1;
    chk(CHIP_SELECT_N === 1'b1 && WRITE_STROBE_N === 1'b1 && OUTPUT_DRIVE_N === 1'b1, "strobes in reset");
    chk(DATA_LINES_OE === 1'b0 && REQ_READY === 1'b0, "outputs in reset");
    t_power;
    rd(19'h7ffff, 8'ha5);
  endtask : t_reset_mid
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (8) @(posedge REF_CLK);
    t_power;
    t_rw;
    t_reset_mid;
    close_out;
  end
  initial
  begin
    #200000;
    errors++;
    close_out;
  end
endmodule : sram_ctl_tb
